/* src/lsmr_pkg.sv */
`default_nettype none
package lsmr_pkg;

  // ------------------------------------------------------------------
  // widths and instance numbers
  // ------------------------------------------------------------------
  localparam int INST_W  = 16;
  localparam int DATA_W  = 64;
  localparam int FLOAT_W = 32;
  localparam int QUES_W  = 13;

  localparam logic [INST_W-1:0] INST_QUESTIONABLE = 16'h000b;
  localparam logic [INST_W-1:0] INST_STATUS       = 16'h000d;
  localparam logic [INST_W-1:0] INST_FAULT_CLEAR  = 16'h000e;
  localparam logic [INST_W-1:0] INST_INPUT_ENABLE = 16'h0011;
  localparam logic [INST_W-1:0] INST_CURRENT      = 16'h0101;
  localparam logic [INST_W-1:0] INST_VOLTAGE      = 16'h0102;
  localparam logic [INST_W-1:0] INST_POWER        = 16'h0103;
  localparam logic [INST_W-1:0] INST_RESISTANCE   = 16'h0104;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic              INPUT_EN_RST = 1'b0;
  localparam logic              LATCH_RST    = 1'b0;
  localparam logic [DATA_W-1:0] DATA_RST     = 64'h0000_0000_0000_0000;

  // ------------------------------------------------------------------
  // operation status word, bit 63 first
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [20:0] unused_hi;               // 63..43
    logic        hard_fault_shutdown;     // 42
    logic        soft_fault_shutdown;     // 41
    logic        combined_thermal_fault;  // 40
    logic        analog_input_control;    // 39
    logic        lock_state;              // 38
    logic        sense_terminals_used;    // 37
    logic        extended_range_active;   // 36
    logic        reg_state_watts;         // 35
    logic        reg_state_ohms;          // 34
    logic        reg_state_volts;         // 33
    logic        reg_state_amps;          // 32
    logic        spare31;                 // 31
    logic        targets_updating;        // 30
    logic        regulation_lost;         // 29
    logic        under_min_rated_voltage; // 28
    logic        resistor_module_hot;     // 27
    logic        io_line_fault;           // 26
    logic        firmware_stack_exceeded; // 25
    logic        bad_product_setup;       // 24
    logic        diode_module_hot;        // 23
    logic        maintenance;             // 22
    logic        spare21;                 // 21
    logic        interlock_open;          // 20
    logic        aux_supply_fuse_open;    // 19
    logic        linear_module_hot;       // 18
    logic        volt_rating_exceeded;    // 17
    logic        amp_rating_exceeded;     // 16
    logic        comm_corrupted;          // 15
    logic        phase_amp_exceeded;      // 14
    logic        target_start_pending;    // 13
    logic        target_start_failed;     // 12
    logic        resistor_stage_overload; // 11
    logic        linear_stage_overload;   // 10
    logic        shutdown_active;         // 9
    logic        low_volt_trip_flag;      // 8
    logic        sense_bounds_flag;       // 7
    logic        watt_trip_flag;          // 6
    logic        high_volt_trip_flag;     // 5
    logic        amp_trip_flag;           // 4
    logic [1:0]  spare_lo;                // 3..2
    logic        input_live;              // 1
    logic        input_standby;           // 0
  } lsmr_status_t;

  // averaged measurements, 32-bit float each, plus the one-bit sense engaged flag
  typedef struct packed {
    logic [FLOAT_W-1:0] current;
    logic [FLOAT_W-1:0] terminal_voltage;
    logic [FLOAT_W-1:0] sense_voltage;
    logic [FLOAT_W-1:0] power;
    logic [FLOAT_W-1:0] resistance;
    logic               sense_engaged;
  } lsmr_meas_t;

  // get / set service request
  typedef struct packed {
    logic              get;
    logic              set;
    logic [INST_W-1:0] inst_num;
    logic              value;
  } lsmr_req_t;

  // service answer
  typedef struct packed {
    logic              valid;
    logic              error;
    logic [DATA_W-1:0] data;
  } lsmr_ans_t;

  // whole state of the register bank
  typedef struct packed {
    logic         input_en;
    logic         fault_latch;
    logic         soft_cause;
    logic         hard_cause;
    lsmr_status_t status;
    lsmr_ans_t    ans;
  } lsmr_state_t;

endpackage : lsmr_pkg
`default_nettype wire

/* src/lsmr_regs.sv */
// Notes on behaviour
// - status word read-only, mirrors present conditions; bits 0, 1, 41, 42 come from input state and fault latch.
// - reading the status word changes nothing.
// - questionable word is a fixed subset of the status word, plus OR summary bits 11 and 12.
// - bit 0 set in standby, bit 1 set while input sinks.
// - bits 4,5,6 current, voltage, power trips; 7 sense bounds; 8 undervoltage.
// - bit 9 set whenever a target causes shutdown.
// - bits 10, 11 stage overloads; bit 14 phase current exceeded.
// - bit 12 start failed, 13 start pending, 30 targets updating.
// - bit 15 internal communication corrupted, bit 25 firmware stack exceeded.
// - bits 16,17 rating exceeded; 19 fuse blown; 20 interlock open.
// - bits 18, 23, 27 module overtemperature; 40 linear-or-resistor combined.
// - bits 22, 24, 26, 28, 29 maintenance, setup, line, voltage, regulation.
// - bits 32-35 regulation state; 36-39 range, sense, lock, analog control.
// - bit 41 shutdown from soft fault, bit 42 from hard fault.
// - boolean write to fault clear releases the input-disable latch.
// - clear refused while any fault condition remains present.
// - clearing a fault leaves the input off until a new start.
// - boolean write enables or disables input; disabled means high impedance.
// - current instance returns averaged terminal current as float.
// - voltage instance returns terminal voltage, or sense voltage when engaged and sense terminals used.
// - power instance returns averaged terminal power as float.
`default_nettype none
module lsmr_regs (
  input  wire logic                 i_clk,
  input  wire logic                 i_srst,
  input  wire lsmr_pkg::lsmr_req_t  i_req,
  input  wire lsmr_pkg::lsmr_status_t i_cond,
  input  wire lsmr_pkg::lsmr_meas_t i_meas,
  output var  lsmr_pkg::lsmr_ans_t  o_ans,
  output var  lsmr_pkg::lsmr_status_t o_status,
  output logic [lsmr_pkg::QUES_W-1:0] o_questionable,
  output logic                      o_fault_latched,
  output logic                      o_input_on,
  output logic                      o_input_hiz
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  lsmr_pkg::lsmr_state_t  st;
  lsmr_pkg::lsmr_state_t  next_st;
  lsmr_pkg::lsmr_status_t live_word;
  logic                   soft_now;
  logic                   hard_now;
  logic                   fault_now;
  logic                   live_on;
  logic                   clr_req;
  logic                   en_req;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------

  // fixed questionable layout picked out of the status word
  function automatic logic [lsmr_pkg::QUES_W-1:0] ques_of(input lsmr_pkg::lsmr_status_t s);
    logic [lsmr_pkg::QUES_W-1:0] q;
    q     = '0;
    q[0]  = s.volt_rating_exceeded;
    q[1]  = s.amp_trip_flag;
    q[2]  = s.high_volt_trip_flag;
    q[3]  = s.watt_trip_flag;
    q[4]  = s.amp_rating_exceeded;
    q[5]  = s.combined_thermal_fault;
    q[6]  = s.sense_bounds_flag;
    q[7]  = s.reg_state_amps;
    q[8]  = s.reg_state_volts;
    q[9]  = s.reg_state_ohms;
    q[10] = s.reg_state_watts;
    q[11] = s.amp_trip_flag | s.high_volt_trip_flag | s.watt_trip_flag | s.low_volt_trip_flag;
    q[12] = s.volt_rating_exceeded | s.amp_rating_exceeded | s.combined_thermal_fault | s.sense_bounds_flag;
    return q;
  endfunction : ques_of

  // widen a float to the answer width
  function automatic logic [lsmr_pkg::DATA_W-1:0] widen(input logic [lsmr_pkg::FLOAT_W-1:0] f);
    return {{(lsmr_pkg::DATA_W-lsmr_pkg::FLOAT_W){1'b0}}, f};
  endfunction : widen

  // ------------------------------------------------------------------
  // fault classes and input state
  // ------------------------------------------------------------------

  // soft trips clear by command, hard faults are rating, linear or resistor module overtemperature or sense bounds faults
  assign soft_now  = i_cond.amp_trip_flag | i_cond.high_volt_trip_flag
                   | i_cond.watt_trip_flag | i_cond.low_volt_trip_flag;
  assign hard_now  = i_cond.amp_rating_exceeded | i_cond.volt_rating_exceeded
                   | i_cond.linear_module_hot | i_cond.resistor_module_hot
                   | i_cond.sense_bounds_flag;
  assign fault_now = soft_now | hard_now;
  assign live_on   = st.input_en & ~st.fault_latch;
  assign clr_req   = i_req.set & ~i_req.get & (i_req.inst_num == lsmr_pkg::INST_FAULT_CLEAR) & i_req.value;
  assign en_req    = i_req.set & ~i_req.get & (i_req.inst_num == lsmr_pkg::INST_INPUT_ENABLE);

  // ------------------------------------------------------------------
  // live status word
  // ------------------------------------------------------------------

  // passed straight from conditions, except bits 0, 1 from input state, 40 combined, 41, 42 from the latch, spare bits forced to zero
  always_comb begin
    live_word                        = i_cond;
    live_word.input_standby          = ~live_on;
    live_word.input_live             = live_on;
    live_word.combined_thermal_fault = i_cond.linear_module_hot
                                     | i_cond.resistor_module_hot;
    live_word.soft_fault_shutdown    = st.fault_latch & st.soft_cause;
    live_word.hard_fault_shutdown    = st.fault_latch & st.hard_cause;
    live_word.spare_lo               = '0;
    live_word.spare21                = 1'b0;
    live_word.spare31                = 1'b0;
    live_word.unused_hi              = '0;
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------

  // latch, enable and service answers
  always_comb begin
    next_st           = st;
    next_st.status    = live_word;
    next_st.ans.valid = i_req.get | i_req.set;
    next_st.ans.error = 1'b0;
    next_st.ans.data  = lsmr_pkg::DATA_RST;

    // clear is only honoured with every fault gone
    if (clr_req && st.fault_latch) begin
      if (fault_now) begin
        next_st.ans.error = 1'b1;
      end else begin
        next_st.fault_latch = 1'b0;
        next_st.soft_cause  = 1'b0;
        next_st.hard_cause  = 1'b0;
      end
    end

    // enable write; latch keeps the input off
    if (en_req) begin
      if (i_req.value && st.fault_latch) begin
        next_st.ans.error = 1'b1;
      end else begin
        next_st.input_en = i_req.value;
      end
    end

    // a present fault sets the latch and wins over a clear
    if (fault_now) begin
      next_st.fault_latch = 1'b1;
      next_st.input_en    = 1'b0;
      next_st.soft_cause  = st.soft_cause | soft_now;
      next_st.hard_cause  = st.hard_cause | hard_now;
    end

    // service decode
    if (i_req.get && i_req.set) begin
      next_st.ans.error = 1'b1;
    end else if (i_req.get) begin
      case (i_req.inst_num)
        lsmr_pkg::INST_STATUS: begin
          next_st.ans.data = live_word;
        end
        lsmr_pkg::INST_QUESTIONABLE: begin
          next_st.ans.data = {{(lsmr_pkg::DATA_W-lsmr_pkg::QUES_W){1'b0}}, ques_of(live_word)};
        end
        lsmr_pkg::INST_CURRENT: begin
          next_st.ans.data = widen(i_meas.current);
        end
        lsmr_pkg::INST_VOLTAGE: begin
          if (i_meas.sense_engaged && i_cond.sense_terminals_used) begin
            next_st.ans.data = widen(i_meas.sense_voltage);
          end else begin
            next_st.ans.data = widen(i_meas.terminal_voltage);
          end
        end
        lsmr_pkg::INST_POWER: begin
          next_st.ans.data = widen(i_meas.power);
        end
        lsmr_pkg::INST_RESISTANCE: begin
          next_st.ans.data = widen(i_meas.resistance);
        end
        default: begin
          next_st.ans.error = 1'b1;
        end
      endcase
    end else if (i_req.set) begin
      case (i_req.inst_num)
        lsmr_pkg::INST_FAULT_CLEAR: begin
          next_st.ans.data = lsmr_pkg::DATA_RST;
        end
        lsmr_pkg::INST_INPUT_ENABLE: begin
          next_st.ans.data = lsmr_pkg::DATA_RST;
        end
        default: begin
          next_st.ans.error = 1'b1;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------

  // single state register
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st <= '0;
      st.input_en    <= lsmr_pkg::INPUT_EN_RST;
      st.fault_latch <= lsmr_pkg::LATCH_RST;
      st.status.input_standby <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign o_ans           = st.ans;
  assign o_status        = st.status;
  assign o_questionable  = ques_of(st.status);
  assign o_fault_latched = st.fault_latch;
  assign o_input_on      = live_on;
  assign o_input_hiz     = ~live_on;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  a_status_follows: assert property (
    $rose(i_cond.amp_rating_exceeded) |=> o_status.amp_rating_exceeded ##1
      (o_status.amp_rating_exceeded == $past(i_cond.amp_rating_exceeded)))
    else $error("status bit did not follow its condition");

  a_status_read: assert property (
    (i_req.get && !i_req.set && i_req.inst_num == lsmr_pkg::INST_STATUS)
      |=> o_ans.valid && !o_ans.error && o_ans.data == o_status)
    else $error("status read returned wrong word");

  a_ques_subset: assert property (
    o_questionable[1] == o_status.amp_trip_flag && o_questionable[5] == o_status.combined_thermal_fault
      && o_questionable[10] == o_status.reg_state_watts && o_questionable[0] == o_status.volt_rating_exceeded)
    else $error("questionable bits disagree with status word");

  a_standby_live: assert property (
    (o_status.input_standby != o_status.input_live) && ($past(o_input_on) == o_status.input_live))
    else $error("standby and live bits inconsistent");

  a_trip_bits: assert property (
    $rose(i_cond.low_volt_trip_flag) |=> o_status.low_volt_trip_flag && o_fault_latched)
    else $error("undervoltage trip not reported");

  a_thermal_combined: assert property (
    ##1 o_status.combined_thermal_fault == $past(i_cond.linear_module_hot || i_cond.resistor_module_hot))
    else $error("combined thermal bit wrong");

  a_shutdown_cause: assert property (
    ($rose(i_cond.watt_trip_flag) && !o_fault_latched) |=> ##1 o_status.soft_fault_shutdown)
    else $error("soft fault shutdown bit missing");

  a_spare_zero: assert property (
    o_status.unused_hi == '0 && o_status.spare_lo == '0 && !o_status.spare21 && !o_status.spare31)
    else $error("unused status bit set");

  a_clear_release: assert property (
    (clr_req && !fault_now) |=> !o_fault_latched)
    else $error("fault clear did not release latch");

  a_clear_refused: assert property (
    (clr_req && fault_now && o_fault_latched) |=> o_fault_latched && o_ans.error)
    else $error("fault clear accepted with fault present");

  a_clear_no_start: assert property (
    (!o_input_on && !(en_req && i_req.value)) |=> !o_input_on)
    else $error("input came back without start");

  a_input_hiz: assert property (
    (en_req && !i_req.value) |=> o_input_hiz && !o_input_on)
    else $error("disabled input not high impedance");

  a_meas_current: assert property (
    (i_req.get && !i_req.set && i_req.inst_num == lsmr_pkg::INST_CURRENT)
      |=> o_ans.data == widen($past(i_meas.current)))
    else $error("current read wrong");

  a_meas_voltage: assert property (
    (i_req.get && !i_req.set && i_req.inst_num == lsmr_pkg::INST_VOLTAGE && i_meas.sense_engaged
      && i_cond.sense_terminals_used) |=> o_ans.data == widen($past(i_meas.sense_voltage)))
    else $error("sense voltage not returned");

  a_meas_power: assert property (
    (i_req.get && !i_req.set && i_req.inst_num == lsmr_pkg::INST_POWER)
      |=> o_ans.data == widen($past(i_meas.power)))
    else $error("power read wrong");

  a_meas_resist: assert property (
    (i_req.get && !i_req.set && i_req.inst_num == lsmr_pkg::INST_RESISTANCE)
      |=> o_ans.data == widen($past(i_meas.resistance)) && !o_ans.error)
    else $error("resistance read wrong");

  // ------------------------------------------------------------------
  // status mirror and latch checks
  // ------------------------------------------------------------------

  a_trip_mirror: assert property (
    ##1 {o_status.amp_trip_flag, o_status.high_volt_trip_flag, o_status.watt_trip_flag,
      o_status.sense_bounds_flag, o_status.low_volt_trip_flag}
      == $past({i_cond.amp_trip_flag, i_cond.high_volt_trip_flag, i_cond.watt_trip_flag,
      i_cond.sense_bounds_flag, i_cond.low_volt_trip_flag}))
    else $error("trip bits do not follow conditions");

  a_shutdown_mirror: assert property (
    ##1 o_status.shutdown_active == $past(i_cond.shutdown_active))
    else $error("shutdown bit does not follow condition");

  a_stage_mirror: assert property (
    ##1 {o_status.linear_stage_overload, o_status.resistor_stage_overload, o_status.phase_amp_exceeded}
      == $past({i_cond.linear_stage_overload, i_cond.resistor_stage_overload,
      i_cond.phase_amp_exceeded}))
    else $error("stage overload bits do not follow conditions");

  a_boot_mirror: assert property (
    ##1 {o_status.target_start_failed, o_status.target_start_pending, o_status.targets_updating}
      == $past({i_cond.target_start_failed, i_cond.target_start_pending, i_cond.targets_updating}))
    else $error("start bits do not follow conditions");

  a_comm_mirror: assert property (
    ##1 {o_status.comm_corrupted, o_status.firmware_stack_exceeded}
      == $past({i_cond.comm_corrupted, i_cond.firmware_stack_exceeded}))
    else $error("communication or stack bit does not follow condition");

  a_rating_mirror: assert property (
    ##1 {o_status.amp_rating_exceeded, o_status.volt_rating_exceeded, o_status.aux_supply_fuse_open,
      o_status.interlock_open} == $past({i_cond.amp_rating_exceeded, i_cond.volt_rating_exceeded,
      i_cond.aux_supply_fuse_open, i_cond.interlock_open}))
    else $error("rating, fuse or interlock bit does not follow condition");

  a_module_hot: assert property (
    ##1 {o_status.linear_module_hot, o_status.diode_module_hot, o_status.resistor_module_hot}
      == $past({i_cond.linear_module_hot, i_cond.diode_module_hot, i_cond.resistor_module_hot}))
    else $error("module temperature bits do not follow conditions");

  a_misc_mirror: assert property (
    ##1 {o_status.maintenance, o_status.bad_product_setup, o_status.io_line_fault,
      o_status.under_min_rated_voltage, o_status.regulation_lost}
      == $past({i_cond.maintenance, i_cond.bad_product_setup, i_cond.io_line_fault,
      i_cond.under_min_rated_voltage, i_cond.regulation_lost}))
    else $error("maintenance or regulation bits do not follow conditions");

  a_reg_state: assert property (
    ##1 {o_status.reg_state_amps, o_status.reg_state_volts, o_status.reg_state_ohms, o_status.reg_state_watts,
      o_status.extended_range_active, o_status.sense_terminals_used, o_status.lock_state,
      o_status.analog_input_control} == $past({i_cond.reg_state_amps, i_cond.reg_state_volts,
      i_cond.reg_state_ohms, i_cond.reg_state_watts, i_cond.extended_range_active,
      i_cond.sense_terminals_used, i_cond.lock_state, i_cond.analog_input_control}))
    else $error("regulation state or mode bits do not follow conditions");

  a_hard_cause: assert property (
    ($rose(i_cond.amp_rating_exceeded) && !o_fault_latched) |=> ##1 o_status.hard_fault_shutdown)
    else $error("hard fault shutdown bit missing");

  a_latch_on_fault: assert property (
    fault_now |=> o_fault_latched && !o_input_on)
    else $error("fault did not latch the input off");

  a_enable_refused: assert property (
    (en_req && i_req.value && o_fault_latched) |=> o_ans.error && !o_input_on)
    else $error("input enabled while fault latched");

endmodule : lsmr_regs
`default_nettype wire

/* tb/lsmr_client.sv */
`default_nettype none
module lsmr_client (
  input  wire logic                i_clk,
  input  wire lsmr_pkg::lsmr_ans_t i_ans,
  output var  lsmr_pkg::lsmr_req_t o_req
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle service port from time zero
  initial o_req = '0;

  // one get or set, driven at the falling edge, answer taken one cycle on
  task automatic svc(input logic g, input logic s, input logic [15:0] inst, input logic v,
                     output logic [63:0] d, output logic e);
    @(negedge i_clk);
    o_req = '{get: g, set: s, inst_num: inst, value: v};
    @(negedge i_clk);
    o_req = '0;
    d = i_ans.data;
    e = i_ans.valid ? i_ans.error : 1'bx; // no answer shows as unknown
  endtask : svc
endmodule : lsmr_client
`default_nettype wire

/* tb/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // signals and parts
  // ------------------------------------------------------------
  logic                   i_clk;
  logic                   i_srst;
  lsmr_pkg::lsmr_req_t    req;
  lsmr_pkg::lsmr_ans_t    ans;
  lsmr_pkg::lsmr_status_t cond;
  lsmr_pkg::lsmr_status_t stat;
  lsmr_pkg::lsmr_meas_t   meas;
  logic [12:0]            ques;
  logic                   latched;
  logic                   on;
  logic                   hiz;
  logic [63:0]            d;
  logic                   e;
  logic [63:0]            x;
  int                     n_fail;
  int                     n_compared;
  int                     live_b[25] = '{9, 10, 11, 12, 13, 14, 15, 19, 20, 22, 23, 24, 25, 26, 28, 29, 30,
                                         32, 33, 34, 35, 36, 37, 38, 39};
  int                     flt_b[9]   = '{4, 5, 6, 7, 8, 16, 17, 18, 27};
  logic [12:0]            flt_q[9]   = '{13'h0802, 13'h0804, 13'h0808, 13'h1040, 13'h0800, 13'h1010, 13'h1001,
                                         13'h1020, 13'h1020};

  lsmr_regs uut (
    .i_clk           (i_clk),
    .i_srst          (i_srst),
    .i_req           (req),
    .i_cond          (cond),
    .i_meas          (meas),
    .o_ans           (ans),
    .o_status        (stat),
    .o_questionable  (ques),
    .o_fault_latched (latched),
    .o_input_on      (on),
    .o_input_hiz     (hiz)
  );

  lsmr_client cl (.i_clk(i_clk), .i_ans(ans), .o_req(req));

  // 200 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // ------------------------------------------------------------
  // compare, service and closing tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rd(input logic [15:0] inst, input logic err, input logic [63:0] exp);
    cl.svc(1'b1, 1'b0, inst, 1'b0, d, e);
    chk(64'(e), 64'(err));
    if (!err) chk(d, exp);
  endtask : rd

  task automatic wr(input logic [15:0] inst, input logic v, input logic err);
    cl.svc(1'b0, 1'b1, inst, v, d, e);
    chk(64'(e), 64'(err));
  endtask : wr

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // hang guard, far beyond the expected run
  initial begin
    #20us;
    n_fail++;
    final_report();
  end

  // reset, then the service sequences
  initial begin
    cond = '0;
    meas = '0;
    i_srst = 1'b1;
    repeat (20) @(negedge i_clk);
    i_srst = 1'b0;
    @(negedge i_clk);
    chk(stat, 64'h1);
    chk(64'({latched, on, hiz}), 64'h1);
    wr(lsmr_pkg::INST_INPUT_ENABLE, 1'b1, 1'b0);
    chk(64'({on, hiz}), 64'h2);
    rd(lsmr_pkg::INST_STATUS, 1'b0, 64'h2);
    wr(lsmr_pkg::INST_INPUT_ENABLE, 1'b0, 1'b0);
    chk(64'({on, hiz}), 64'h1);
    rd(lsmr_pkg::INST_STATUS, 1'b0, 64'h1);
    wr(lsmr_pkg::INST_INPUT_ENABLE, 1'b1, 1'b0);
    // each live flag mirrored at its own position
    foreach (live_b[i]) begin
      cond = 64'h1 << live_b[i];
      rd(lsmr_pkg::INST_STATUS, 1'b0, (64'h1 << live_b[i]) | 64'h2);
      chk(stat, (64'h1 << live_b[i]) | 64'h2);
    end
    // spare and device-owned positions driven high
    cond = 64'hffff_ff00_8060_000f;
    rd(lsmr_pkg::INST_STATUS, 1'b0, 64'h0000_0000_0040_0002);
    rd(lsmr_pkg::INST_STATUS, 1'b0, 64'h0000_0000_0040_0002);
    cond = 64'h0000_000f_0040_0000;
    rd(lsmr_pkg::INST_QUESTIONABLE, 1'b0, 64'h0780);
    chk(64'(ques), 64'h0780);
    // measurements, voltage from sense terminals when engaged and in use
    meas = '{32'h3f80_0000, 32'h4120_0000, 32'h4110_0000, 32'h4248_0000, 32'h4000_0000, 1'b1};
    cond = '0;
    rd(lsmr_pkg::INST_CURRENT, 1'b0, 64'h3f80_0000);
    rd(lsmr_pkg::INST_VOLTAGE, 1'b0, 64'h4120_0000);
    cond = 64'h0000_0020_0000_0000;
    rd(lsmr_pkg::INST_VOLTAGE, 1'b0, 64'h4110_0000);
    meas.sense_engaged = 1'b0;
    rd(lsmr_pkg::INST_VOLTAGE, 1'b0, 64'h4120_0000);
    rd(lsmr_pkg::INST_POWER, 1'b0, 64'h4248_0000);
    rd(lsmr_pkg::INST_RESISTANCE, 1'b0, 64'h4000_0000);
    // wrong-direction and unknown instances
    rd(lsmr_pkg::INST_FAULT_CLEAR, 1'b1, 64'h0);
    rd(lsmr_pkg::INST_INPUT_ENABLE, 1'b1, 64'h0);
    rd(16'h0200, 1'b1, 64'h0);
    wr(lsmr_pkg::INST_STATUS, 1'b1, 1'b1);
    cond = '0;
    // every soft trip and hard fault: latch, refused clear, clear, separate restart
    foreach (flt_b[i]) begin
      x = (64'h1 << flt_b[i]) | 64'h1;
      x = x | ((flt_b[i] inside {4, 5, 6, 8}) ? 64'h0000_0200_0000_0000 : 64'h0000_0400_0000_0000);
      if (flt_b[i] inside {18, 27}) x = x | 64'h0000_0100_0000_0000;
      cond = 64'h1 << flt_b[i];
      repeat (3) @(negedge i_clk);
      chk(64'({latched, on, hiz}), 64'h5);
      chk(64'(ques), 64'(flt_q[i]));
      rd(lsmr_pkg::INST_STATUS, 1'b0, x);
      wr(lsmr_pkg::INST_INPUT_ENABLE, 1'b1, 1'b1);
      wr(lsmr_pkg::INST_FAULT_CLEAR, 1'b1, 1'b1);
      cond = '0;
      wr(lsmr_pkg::INST_FAULT_CLEAR, 1'b1, 1'b0);
      rd(lsmr_pkg::INST_STATUS, 1'b0, 64'h1);
      wr(lsmr_pkg::INST_INPUT_ENABLE, 1'b1, 1'b0);
      chk(64'({latched, on}), 64'h1);
    end
    // reset in mid-run while a trip holds the latch
    cond = 64'h0000_0000_0000_0010;
    repeat (3) @(negedge i_clk);
    chk(64'(latched), 64'h1);
    i_srst = 1'b1;
    cond = '0;
    repeat (3) @(negedge i_clk);
    i_srst = 1'b0;
    @(negedge i_clk);
    chk(64'({latched, on, hiz}), 64'h1);
    chk(stat, 64'h1);
    final_report();
  end
endmodule : testbench
`default_nettype wire
